// [rtl/pwdt_pkg.sv]
// Purpose: Shared constants and types of the pulse width demodulation timer.
// Assumes: 8-bit register bus, 4-bit register offsets.
// Notes:   Offsets are byte offsets on the plain register port.
`default_nettype none

package pwdt_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 4;

  // Register offsets
  localparam logic [AW-1:0] OFS_CTRL_COMMON = 4'h0;
  localparam logic [AW-1:0] OFS_CTRL_ONE    = 4'h1;
  localparam logic [AW-1:0] OFS_CONST_LOW   = 4'h4;
  localparam logic [AW-1:0] OFS_CONST_HIGH  = 4'h5;
  localparam logic [AW-1:0] OFS_CAP_LOW     = 4'hA;
  localparam logic [AW-1:0] OFS_CAP_HIGH    = 4'hB;

  // Common control fields
  localparam int unsigned COM_EN_BIT    = 0;
  localparam int unsigned COM_IRQEN_BIT = 2;
  localparam int unsigned COM_TMO_BIT   = 5;

  // Control one fields
  localparam int unsigned ONE_STR_BIT  = 0;
  localparam int unsigned ONE_STF_BIT  = 1;
  localparam int unsigned ONE_LVL_BIT  = 1;
  localparam int unsigned ONE_RISE_BIT = 4;
  localparam int unsigned ONE_FALL_BIT = 5;
  localparam int unsigned ONE_MODE_BIT = 7;

  // Reset and reload values
  localparam logic [DW-1:0] RST_CONST  = 8'hFF;
  localparam logic [DW-1:0] CNT_RELOAD = 8'hFF;
  localparam logic [DW-1:0] CNT_ZERO   = 8'h00;
  localparam logic [DW-1:0] CNT_STEP   = 8'h01;

  // Capture store entries
  localparam logic CAP_IDX_LOW  = 1'b0;
  localparam logic CAP_IDX_HIGH = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ARMED = 3'h2,
    ST_COUNT = 3'h4
  } pwdt_state_e;

endpackage : pwdt_pkg

`default_nettype wire

// [rtl/pwdt_cap_store.sv]
// Purpose: Capture store with registered read port.
// Assumes: One hardware write port, no software write path.
// Notes:   Read data stand for one cycle after the read strobe, else zero.
`default_nettype none

module pwdt_cap_store
  import pwdt_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  input  wire logic                     i_clk_en,
  // Hardware write
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  // Read
  input  wire logic                     i_rd,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  input  wire logic                     i_use_alt,
  input  wire logic [WIDTH-1:0]         i_alt_data,
  output logic      [WIDTH-1:0]         o_rdata
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rdata_nxt;

  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      logic [WIDTH-1:0] ent_nxt;
      always_comb begin
        ent_nxt = mem_r[g];
        if (i_we && (i_waddr == ($clog2(DEPTH))'(g))) begin
          ent_nxt = i_wdata;
        end
      end
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          mem_r[g] <= '0;
        end else if (i_clk_en) begin
          mem_r[g] <= ent_nxt;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      rdata_nxt = i_use_alt ? i_alt_data : mem_r[i_raddr];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule : pwdt_cap_store

`default_nettype wire

// [rtl/pwdt_timer.sv]
// Purpose: 8-bit down counter with transmit and edge timing demodulation modes.
// Assumes: Edge input synchronous-capable, sampled through two flops.
// Notes:   Enable and status clears apply one enabled clock after the write.
// Function
// - Before transmit start, output is high when level bit is 0, low when 1.
// - Stop and status-clear commands take effect one timer clock later.
// - Demodulation starts counting at first edge of selected polarity.
// - Later qualified edges capture the complemented current count.
// - Rising-edge captures go to low phase, falling to high phase.
// - Each capture sets its matching edge status bit.
// - Capture raises the interrupt request only when enabled.
// - Each capture reloads the counter with FFh and keeps counting.
// - Counter reaching zero in demodulation sets the time-out status bit.
// - High phase capture holds captured value; software writes ignored.
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none

module pwdt_timer
  import pwdt_pkg::*;
(
  // Clock, enable and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_clk_en,
  input  wire logic          i_reset,
  // Register port
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  // Link
  input  wire logic          i_edge_in,
  output logic               o_byte_timer_output,
  output logic               o_timer_irq
);

  // Control state
  logic          en_r, en_nxt, irq_en_r, irq_en_nxt;
  logic          en_pend_r, en_pend_nxt, en_val_r, en_val_nxt;
  logic          demod_r, demod_nxt, rise_sel_r, rise_sel_nxt;
  logic          fall_sel_r, fall_sel_nxt, level_r, level_nxt;
  logic          tmo_r, tmo_nxt;
  logic [1:0]    edge_stat_r, edge_stat_nxt;
  logic [2:0]    clr_pend_r, clr_pend_nxt;
  logic [DW-1:0] const_lo_r, const_lo_nxt, const_hi_r, const_hi_nxt;
  // Datapath state
  pwdt_state_e   state_r, state_nxt;
  logic [DW-1:0] cnt_r, cnt_nxt;
  logic          out_r, out_nxt, irq_r, irq_nxt;
  logic          sync_a_r, sync_b_r, prev_r;
  // Events
  logic          rise_evt, fall_evt, qual;
  logic          cap_we, tmo_set, rise_set, fall_set;
  logic [DW-1:0] cap_data;
  logic          wr_common, wr_one;
  logic [DW-1:0] alt_data;
  logic          rd_cap;

  assign wr_common = i_wr && (i_addr == OFS_CTRL_COMMON);
  assign wr_one    = i_wr && (i_addr == OFS_CTRL_ONE);

  always_comb begin
    en_nxt        = en_r;
    en_pend_nxt   = 1'b0;
    en_val_nxt    = en_val_r;
    irq_en_nxt    = irq_en_r;
    demod_nxt     = demod_r;
    rise_sel_nxt  = rise_sel_r;
    fall_sel_nxt  = fall_sel_r;
    level_nxt     = level_r;
    const_lo_nxt  = const_lo_r;
    const_hi_nxt  = const_hi_r;
    clr_pend_nxt  = 3'h0;
    // Delayed commands land now; a same-cycle hardware set beats the clear
    if (en_pend_r) begin
      en_nxt = en_val_r;
    end
    tmo_nxt       = (tmo_r & ~clr_pend_r[2]) | tmo_set;
    edge_stat_nxt = (edge_stat_r & ~clr_pend_r[1:0]) | {fall_set, rise_set};
    if (wr_common) begin
      en_pend_nxt     = 1'b1;
      en_val_nxt      = i_wdata[COM_EN_BIT];
      irq_en_nxt      = i_wdata[COM_IRQEN_BIT];
      clr_pend_nxt[2] = i_wdata[COM_TMO_BIT];
    end
    if (wr_one) begin
      demod_nxt    = i_wdata[ONE_MODE_BIT];
      rise_sel_nxt = i_wdata[ONE_RISE_BIT];
      fall_sel_nxt = i_wdata[ONE_FALL_BIT];
      // Low bits mean status in demodulation, output level in transmit
      if (demod_r) begin
        clr_pend_nxt[1] = i_wdata[ONE_STF_BIT];
        clr_pend_nxt[0] = i_wdata[ONE_STR_BIT];
      end else begin
        level_nxt = i_wdata[ONE_LVL_BIT];
      end
    end
    if (i_wr && (i_addr == OFS_CONST_LOW)) begin
      const_lo_nxt = i_wdata;
    end
    if (i_wr && (i_addr == OFS_CONST_HIGH)) begin
      const_hi_nxt = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      en_r        <= 1'b0;
      en_pend_r   <= 1'b0;
      en_val_r    <= 1'b0;
      irq_en_r    <= 1'b0;
      demod_r     <= 1'b0;
      rise_sel_r  <= 1'b0;
      fall_sel_r  <= 1'b0;
      level_r     <= 1'b0;
      tmo_r       <= 1'b0;
      edge_stat_r <= 2'h0;
      clr_pend_r  <= 3'h0;
      const_lo_r  <= RST_CONST;
      const_hi_r  <= RST_CONST;
    end else if (i_clk_en) begin
      en_r        <= en_nxt;
      en_pend_r   <= en_pend_nxt;
      en_val_r    <= en_val_nxt;
      irq_en_r    <= irq_en_nxt;
      demod_r     <= demod_nxt;
      rise_sel_r  <= rise_sel_nxt;
      fall_sel_r  <= fall_sel_nxt;
      level_r     <= level_nxt;
      tmo_r       <= tmo_nxt;
      edge_stat_r <= edge_stat_nxt;
      clr_pend_r  <= clr_pend_nxt;
      const_lo_r  <= const_lo_nxt;
      const_hi_r  <= const_hi_nxt;
    end
  end

  // Edge detect looks only at the second sync flop
  assign rise_evt = sync_b_r & ~prev_r;
  assign fall_evt = ~sync_b_r & prev_r;
  assign qual     = (rise_evt & rise_sel_r) | (fall_evt & fall_sel_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    cap_we    = 1'b0;
    cap_data  = ~cnt_r;
    tmo_set   = 1'b0;
    rise_set  = 1'b0;
    fall_set  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (!demod_r) begin
          out_nxt = ~level_r;
        end
        if (en_r) begin
          if (demod_r) begin
            state_nxt = ST_ARMED;
          end else begin
            state_nxt = ST_COUNT;
            cnt_nxt   = out_r ? const_hi_r : const_lo_r;
          end
        end
      end
      ST_ARMED: begin
        if (!en_r) begin
          state_nxt = ST_IDLE;
        end else if (qual) begin
          state_nxt = ST_COUNT;
          cnt_nxt   = CNT_RELOAD;
        end
      end
      ST_COUNT: begin
        if (!en_r) begin
          state_nxt = ST_IDLE;
        end else if (demod_r) begin
          if (qual) begin
            cap_we   = 1'b1;
            rise_set = rise_evt;
            fall_set = fall_evt;
            cnt_nxt  = CNT_RELOAD;
          end else if (cnt_r == CNT_ZERO) begin
            tmo_set = 1'b1;
            cnt_nxt = CNT_RELOAD;
          end else begin
            cnt_nxt = cnt_r - CNT_STEP;
          end
        end else if (cnt_r == CNT_ZERO) begin
          // Transmit: toggle, then time the new phase
          out_nxt = ~out_r;
          cnt_nxt = out_r ? const_lo_r : const_hi_r;
        end else begin
          cnt_nxt = cnt_r - CNT_STEP;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    irq_nxt = irq_en_r & (cap_we | tmo_set);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r  <= ST_IDLE;
      cnt_r    <= CNT_RELOAD;
      out_r    <= 1'b1;
      irq_r    <= 1'b0;
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
      prev_r   <= 1'b0;
    end else if (i_clk_en) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      out_r    <= out_nxt;
      irq_r    <= irq_nxt;
      sync_a_r <= i_edge_in;
      sync_b_r <= sync_a_r;
      prev_r   <= sync_b_r;
    end
  end

  assign o_byte_timer_output = out_r;
  assign o_timer_irq         = irq_r;

  // Readback of the control and status registers
  always_comb begin
    alt_data = '0;
    case (i_addr)
      OFS_CTRL_COMMON: begin
        alt_data[COM_EN_BIT]    = en_r;
        alt_data[COM_IRQEN_BIT] = irq_en_r;
        alt_data[COM_TMO_BIT]   = tmo_r;
      end
      OFS_CTRL_ONE: begin
        alt_data[ONE_MODE_BIT] = demod_r;
        alt_data[ONE_FALL_BIT] = fall_sel_r;
        alt_data[ONE_RISE_BIT] = rise_sel_r;
        if (demod_r) begin
          alt_data[ONE_STF_BIT] = edge_stat_r[1];
          alt_data[ONE_STR_BIT] = edge_stat_r[0];
        end else begin
          alt_data[ONE_LVL_BIT] = level_r;
        end
      end
      OFS_CONST_LOW:  alt_data = const_lo_r;
      OFS_CONST_HIGH: alt_data = const_hi_r;
      default:        alt_data = '0;
    endcase
  end

  assign rd_cap = (i_addr == OFS_CAP_LOW) || (i_addr == OFS_CAP_HIGH);

  // Captures have no software write path at all
  pwdt_cap_store #(
    .WIDTH (DW),
    .DEPTH (2)
  ) u_cap_store (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_we       (cap_we),
    .i_waddr    (fall_evt ? CAP_IDX_HIGH : CAP_IDX_LOW),
    .i_wdata    (cap_data),
    .i_rd       (i_rd),
    .i_raddr    (i_addr == OFS_CAP_HIGH),
    .i_use_alt  (!rd_cap),
    .i_alt_data (alt_data),
    .o_rdata    (o_rdata)
  );

  sequence s_stop_cmd;
    i_clk_en && wr_common && !i_wdata[COM_EN_BIT] && en_r;
  endsequence
  sequence s_quiet;
    i_clk_en && !i_wr;
  endsequence
  sequence s_cap_rise;
    i_clk_en && state_r == ST_COUNT && demod_r && en_r && rise_evt && rise_sel_r;
  endsequence
  sequence s_cap_fall;
    i_clk_en && state_r == ST_COUNT && demod_r && en_r && fall_evt && fall_sel_r;
  endsequence

  AST_IDLE_LEVEL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_clk_en && state_r == ST_IDLE && !demod_r |=> o_byte_timer_output == !$past(level_r))
    else $error("idle output does not follow level bit");

  AST_STOP_DELAY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_stop_cmd ##1 s_quiet |-> en_r ##1 !en_r)
    else $error("stop not applied exactly one clock later");

  AST_START_EDGE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_clk_en && state_r == ST_ARMED && en_r && qual |=> state_r == ST_COUNT && cnt_r == CNT_RELOAD)
    else $error("count did not start on qualified edge");

  AST_CAP_LOW: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_cap_rise |-> cap_we && cap_data == ~cnt_r && !fall_evt)
    else $error("rising capture wrong value or target");

  AST_STATUS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_cap_fall |=> edge_stat_r[1] ##1 (edge_stat_r[1] || $past(clr_pend_r[1])))
    else $error("falling edge status not set");

  AST_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_clk_en && (cap_we || tmo_set) |=> o_timer_irq == $past(irq_en_r))
    else $error("interrupt does not follow enable");

  AST_RELOAD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_cap_rise or s_cap_fall |=> cnt_r == CNT_RELOAD && state_r == ST_COUNT)
    else $error("counter not reloaded on capture");

  AST_TIMEOUT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_clk_en && state_r == ST_COUNT && demod_r && en_r && !qual && cnt_r == CNT_ZERO
    |=> tmo_r && o_timer_irq == $past(irq_en_r))
    else $error("time-out status not set at zero");

  AST_DECR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_clk_en && state_r == ST_COUNT && en_r && !qual && cnt_r != CNT_ZERO
    |=> cnt_r == $past(cnt_r) - CNT_STEP)
    else $error("counter did not step by one");

endmodule : pwdt_timer

`default_nettype wire

// [verification/pwdt_edge_src.sv]
// Purpose: Model of the pulse-coded source feeding the timer edge input.
// Assumes: Source always drives a solid level; changes land just after a clock edge.
// Notes:   Successive steps are spaced exactly by their hold counts in clock cycles.
`default_nettype none

module pwdt_edge_src (
  // Clock
  input  wire logic i_ref_clk,
  // Pulse-coded line
  output var  logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_line = 1'b0;
  end

  // Hold counts chosen by the bench keep edges inside one timer period, except the 300-cycle hold that forces a time-out
  task automatic step(input logic lvl, input int hold);
    @(posedge i_ref_clk);
    o_line <= lvl;
    repeat (hold - 1) @(posedge i_ref_clk);
  endtask : step

endmodule : pwdt_edge_src

`default_nettype wire

// [verification/pulse_width_demod_timer_bench.sv]
// Purpose: Self-checking bench of the pulse width demodulation timer.
// Assumes: Clock enable high except in one freeze step; register port driven at rising edges.
// Notes:   Capture figures are derived from the edge spacing set by the bench.
`default_nettype none

module pulse_width_demod_timer_bench import pwdt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic          i_ref_clk;
  logic          i_reset;
  logic          i_clk_en;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata;
  logic          i_wr;
  logic          i_rd;
  logic [DW-1:0] o_rdata;
  wire  logic    edge_line;
  logic          o_byte_timer_output;
  logic          o_timer_irq;
  int            mismatches;
  int            samples_checked;
  int            irq_count;
  int            cycles;

  pwdt_timer DUT (
    .i_ref_clk           (i_ref_clk),
    .i_clk_en            (i_clk_en),
    .i_reset             (i_reset),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .i_wr                (i_wr),
    .i_rd                (i_rd),
    .o_rdata             (o_rdata),
    .i_edge_in           (edge_line),
    .o_byte_timer_output (o_byte_timer_output),
    .o_timer_irq         (o_timer_irq)
  );

  pwdt_edge_src src (
    .i_ref_clk (i_ref_clk),
    .o_line    (edge_line)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Registered pulse is sampled before the edge's own update lands
  always @(posedge i_ref_clk) begin
    if (o_timer_irq === 1'b1) irq_count++;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string name);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    check(name, o_rdata, exp);
  endtask : rd

  task automatic test_reset_values();
    rd(OFS_CONST_LOW, RST_CONST, "const low");
    rd(OFS_CONST_HIGH, RST_CONST, "const high");
    rd(OFS_CTRL_COMMON, 8'h00, "ctrl common");
    rd(4'h7, 8'h00, "unmapped");
    check("output idle", {7'h00, o_byte_timer_output}, 8'h01);
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_transmit_level();
    wr(OFS_CTRL_ONE, 8'h02);
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("level one", {7'h00, o_byte_timer_output}, 8'h00);
    wr(OFS_CTRL_ONE, 8'h00);
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("level zero", {7'h00, o_byte_timer_output}, 8'h01);
    $display("test transmit level done");
  endtask : test_transmit_level

  task automatic test_demod_both();
    int irq0;
    wr(OFS_CONST_LOW, 8'hFF);
    wr(OFS_CONST_HIGH, 8'hFF);
    wr(OFS_CTRL_ONE, 8'hB0);
    wr(OFS_CTRL_COMMON, 8'h05);
    repeat (4) @(posedge i_ref_clk);
    irq0 = irq_count;
    src.step(1'b1, 20);
    src.step(1'b0, 12);
    src.step(1'b1, 8);
    rd(OFS_CAP_HIGH, 8'd19, "high capture");
    rd(OFS_CAP_LOW, 8'd11, "low capture");
    rd(OFS_CTRL_ONE, 8'hB3, "edge status");
    check("capture irqs", 8'(irq_count - irq0), 8'd2);
    wr(OFS_CAP_HIGH, 8'h55);
    rd(OFS_CAP_HIGH, 8'd19, "high capture kept");
    wr(OFS_CTRL_COMMON, 8'h00);
    wr(OFS_CTRL_ONE, 8'hB3);
    rd(OFS_CTRL_ONE, 8'hB0, "status cleared");
    $display("test demod both edges done");
  endtask : test_demod_both

  task automatic test_timeout();
    int irq0;
    wr(OFS_CTRL_COMMON, 8'h01);
    repeat (4) @(posedge i_ref_clk);
    irq0 = irq_count;
    src.step(1'b0, 300);
    rd(OFS_CTRL_COMMON, 8'h21, "time-out set");
    check("masked irqs", 8'(irq_count - irq0), 8'd0);
    wr(OFS_CTRL_COMMON, 8'h00);
    wr(OFS_CTRL_COMMON, 8'h20);
    rd(OFS_CTRL_COMMON, 8'h00, "time-out cleared");
    $display("test timeout done");
  endtask : test_timeout

  task automatic test_rising_only();
    int irq0;
    wr(OFS_CTRL_ONE, 8'h90);
    wr(OFS_CTRL_COMMON, 8'h05);
    repeat (4) @(posedge i_ref_clk);
    irq0 = irq_count;
    src.step(1'b1, 5);
    src.step(1'b0, 9);
    src.step(1'b1, 8);
    rd(OFS_CAP_LOW, 8'd13, "rising interval");
    rd(OFS_CAP_HIGH, 8'd19, "high untouched");
    check("rising irqs", 8'(irq_count - irq0), 8'd1);
    wr(OFS_CTRL_COMMON, 8'h00);
    $display("test rising only done");
  endtask : test_rising_only

  // Phases of const high + 1 and const low + 1 cycles; a freeze stretches one
  task automatic test_transmit_run();
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CONST_HIGH, 8'h03);
    wr(OFS_CONST_LOW, 8'h02);
    wr(OFS_CTRL_COMMON, 8'h01);
    repeat (5) @(posedge i_ref_clk);
    #1;
    check("high phase", {7'h00, o_byte_timer_output}, 8'h01);
    @(posedge i_ref_clk);
    #1;
    check("first toggle", {7'h00, o_byte_timer_output}, 8'h00);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    check("frozen low", {7'h00, o_byte_timer_output}, 8'h00);
    @(posedge i_ref_clk);
    #1;
    check("second toggle", {7'h00, o_byte_timer_output}, 8'h01);
    wr(OFS_CTRL_COMMON, 8'h00);
    $display("test transmit run done");
  endtask : test_transmit_run

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    i_reset         = 1'b1;
    i_clk_en        = 1'b1;
    i_addr          = '0;
    i_wdata         = '0;
    i_wr            = 1'b0;
    i_rd            = 1'b0;
    mismatches      = 0;
    samples_checked = 0;
    irq_count       = 0;
    cycles          = 0;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    test_reset_values();
    test_transmit_level();
    test_demod_both();
    test_timeout();
    test_rising_only();
    test_transmit_run();
    give_verdict();
  end

endmodule : pulse_width_demod_timer_bench

`default_nettype wire
